// ==== rtl/sesc_pkg.sv ====
`default_nettype none
package sesc_pkg;
    // array geometry (smallest family member: 128 x 8, 16-byte pages)
    localparam int ADDR_W = 7;
    localparam int DEPTH = 128;
    localparam int PAGE_W = 4;
    localparam int PAGE_BYTES = 16;

    // instruction opcodes, msb first on the link
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // status byte layout: [7:4] fixed ones, [3:2] block protect, [1] latch, [0] busy
    localparam logic [3:0] STATUS_FILL = 4'hF;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 3;

    // reset values
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic WEL_RST = 1'b0;

    // self-timed write cycle length
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned WR_CYCLE_NS = 20000;
    localparam logic [15:0] WR_CYCLE_CNT = 16'(WR_CYCLE_NS / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        SESC_RESET = 4'h0,
        SESC_STANDBY = 4'h1,
        SESC_OPCODE = 4'h2,
        SESC_CMD_END = 4'h3,
        SESC_ADDR = 4'h4,
        SESC_WDATA = 4'h5,
        SESC_RDATA = 4'h6,
        SESC_STATUS = 4'h7,
        SESC_IGNORE = 4'h8
    } sesc_state_e;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sesc_pins_s;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wdata;
        logic [ADDR_W-1:0] raddr;
    } sesc_mem_req_s;
endpackage
`default_nettype wire

// ==== rtl/sesc_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module sesc_mem (
    input wire logic ref_clk_i,
    input wire logic ce_i,
    input wire sesc_pkg::sesc_mem_req_s req_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_reg [sesc_pkg::DEPTH];

    // contents are nonvolatile: no reset on the array
    always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
            if (req_i.we) begin
                mem_reg[req_i.waddr] <= req_i.wdata;
            end
            rdata_o <= mem_reg[req_i.raddr];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/sesc_ctrl.sv ====
// Function
// - supply rising above trigger level moves the device from reset to standby.
// - supply falling below trigger level forces reset state, aborting everything.
// - leaving reset clears the write enable latch and enters standby.
// - falling select moves standby to ready, where an opcode is accepted.
// - completing a byte, page or status write clears the write enable latch.
// - internal write cycle starts only on rising select after whole bytes.
// - array accesses during the write cycle are ignored; programming continues.
// - undefined opcode is ignored and serial output stays high impedance.
// - status bit 0 reads 1 for the whole write cycle, else 0.
// - while busy only the status read command is executed.
// - write enable command sets the latch, write disable clears it.
`timescale 1ns/10ps
`default_nettype none
module sesc_ctrl (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic por_ok_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    output logic busy_o,
    output logic wel_o,
    output logic standby_o,
    output logic [1:0] bp_o
);
    // pin synchronisers: stage 1 is read only by stage 2
    sesc_pkg::sesc_pins_s pin1_reg, pin2_reg, pin3_reg, pin1_next, pin2_next, pin3_next;
    logic por1_reg, por2_reg, por1_next, por2_next;
    always_comb begin
        pin1_next = '{cs_n: cs_n_i, sck: sck_i, si: si_i};
        pin2_next = pin1_reg;
        pin3_next = pin2_reg;
        por1_next = por_ok_i;
        por2_next = por1_reg;
    end
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            // idle pin levels, so no false edge follows reset
            {pin1_reg, pin2_reg, pin3_reg} <= 9'h124;
            {por1_reg, por2_reg} <= 2'h0;
        end else if (ce_i) begin
            {pin1_reg, pin2_reg, pin3_reg} <= {pin1_next, pin2_next, pin3_next};
            {por1_reg, por2_reg} <= {por1_next, por2_next};
        end
    end
    logic sck_rise, sck_fall, sel_fall, sel_rise;
    assign sck_rise = pin2_reg.sck & ~pin3_reg.sck;
    assign sck_fall = ~pin2_reg.sck & pin3_reg.sck;
    assign sel_fall = ~pin2_reg.cs_n & pin3_reg.cs_n;
    assign sel_rise = pin2_reg.cs_n & ~pin3_reg.cs_n;
    // control state
    sesc_pkg::sesc_state_e state_reg, state_next;
    logic [7:0] sh_reg, sh_next, osh_reg, osh_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next, out_cnt_reg, out_cnt_next;
    logic [sesc_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] pend_op_reg, pend_op_next;
    logic is_wr_reg, is_wr_next, is_sr_reg, is_sr_next, got_reg, got_next;
    logic [sesc_pkg::PAGE_BYTES-1:0][7:0] buf_reg, buf_next;
    logic [sesc_pkg::PAGE_BYTES-1:0] mask_reg, mask_next;
    logic [1:0] sr_data_reg, sr_data_next, bp_next;
    logic [15:0] wcnt_reg, wcnt_next;
    logic so_next, so_oe_next, busy_next, wel_next, standby_next;
    logic [7:0] shin, status_byte, src, mem_rdata;
    logic [sesc_pkg::PAGE_W-1:0] widx;
    sesc_pkg::sesc_mem_req_s mem_req;
    always_comb begin
        state_next = state_reg;
        {sh_next, osh_next} = {sh_reg, osh_reg};
        {bit_cnt_next, out_cnt_next} = {bit_cnt_reg, out_cnt_reg};
        addr_next = addr_reg;
        pend_op_next = pend_op_reg;
        {is_wr_next, is_sr_next, got_next} = {is_wr_reg, is_sr_reg, got_reg};
        buf_next = buf_reg;
        mask_next = mask_reg;
        sr_data_next = sr_data_reg;
        bp_next = bp_o;
        wcnt_next = wcnt_reg;
        {so_next, so_oe_next, busy_next, wel_next} = {so_o, so_oe_o, busy_o, wel_o};
        shin = {sh_reg[6:0], pin2_reg.si};
        widx = wcnt_reg[sesc_pkg::PAGE_W-1:0];
        status_byte = {sesc_pkg::STATUS_FILL, bp_o, wel_o, busy_o};
        src = (state_reg == sesc_pkg::SESC_STATUS) ? status_byte : mem_rdata;
        mem_req.we = 1'b0;
        mem_req.waddr = {addr_reg[sesc_pkg::ADDR_W-1:sesc_pkg::PAGE_W], widx};
        mem_req.wdata = buf_reg[widx];
        mem_req.raddr = addr_reg;
        // the write cycle runs on regardless of link activity
        if (busy_o) begin
            mem_req.we = ~is_sr_reg & (wcnt_reg < 16'(sesc_pkg::PAGE_BYTES)) & mask_reg[widx];
            wcnt_next = wcnt_reg + 16'h0001;
            if (wcnt_reg == sesc_pkg::WR_CYCLE_CNT - 16'h0001) begin
                // busy drops when commands are accepted again
                busy_next = 1'b0;
                wel_next = 1'b0;
                if (is_sr_reg) begin
                    bp_next = sr_data_reg;
                end
            end
        end
        if (state_reg == sesc_pkg::SESC_RESET) begin
            // clean entry into standby, writes disabled
            if (por2_reg) begin
                state_next = sesc_pkg::SESC_STANDBY;
                wel_next = sesc_pkg::WEL_RST;
            end
        end else if (!por2_reg) begin
            // brown-out drops everything back to reset
            state_next = sesc_pkg::SESC_RESET;
            wel_next = sesc_pkg::WEL_RST;
            busy_next = 1'b0;
            so_oe_next = 1'b0;
        end else if (state_reg == sesc_pkg::SESC_STANDBY) begin
            if (sel_fall) begin
                state_next = sesc_pkg::SESC_OPCODE;
                bit_cnt_next = 3'h0;
                out_cnt_next = 3'h0;
                got_next = 1'b0;
            end
        end else if (sel_rise) begin
            // deselect ends the command, output released
            state_next = sesc_pkg::SESC_STANDBY;
            so_oe_next = 1'b0;
            // latch changes only once select rises after the opcode
            if (state_reg == sesc_pkg::SESC_CMD_END) begin
                wel_next = (pend_op_reg == sesc_pkg::OP_WRITE_ENABLE_CMD);
            end
            // write starts on rising select after whole data bytes
            if (state_reg == sesc_pkg::SESC_WDATA && got_reg && bit_cnt_reg == 3'h0) begin
                busy_next = 1'b1;
                wcnt_next = 16'h0000;
            end
        end else begin
            case (state_reg)
                sesc_pkg::SESC_OPCODE, sesc_pkg::SESC_ADDR, sesc_pkg::SESC_WDATA: begin
                    // msb first, sampled on rising sck
                    if (sck_rise) begin
                        sh_next = shin;
                        bit_cnt_next = bit_cnt_reg + 3'h1;
                    end
                end
                sesc_pkg::SESC_CMD_END: begin
                    // clocks past the opcode spoil the command
                    if (sck_rise) begin
                        state_next = sesc_pkg::SESC_IGNORE;
                    end
                end
                sesc_pkg::SESC_RDATA, sesc_pkg::SESC_STATUS: begin
                    if (sck_fall) begin
                        so_oe_next = 1'b1;
                        out_cnt_next = out_cnt_reg + 3'h1;
                        if (out_cnt_reg == 3'h0) begin
                            so_next = src[7];
                            osh_next = {src[6:0], 1'b0};
                            if (state_reg == sesc_pkg::SESC_RDATA) begin
                                addr_next = addr_reg + 7'h01;
                            end
                        end else begin
                            so_next = osh_reg[7];
                            osh_next = {osh_reg[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                end
            endcase
            if (sck_rise && bit_cnt_reg == 3'h7) begin
                case (state_reg)
                    sesc_pkg::SESC_OPCODE: begin
                        pend_op_next = shin;
                        // while busy only the status read gets through
                        if (busy_o && shin != sesc_pkg::OP_STATUS_READ_CMD) begin
                            state_next = sesc_pkg::SESC_IGNORE;
                        end else begin
                            case (shin)
                                sesc_pkg::OP_WRITE_ENABLE_CMD,
                                sesc_pkg::OP_WRITE_DISABLE_CMD: begin
                                    state_next = sesc_pkg::SESC_CMD_END;
                                end
                                sesc_pkg::OP_STATUS_READ_CMD: begin
                                    state_next = sesc_pkg::SESC_STATUS;
                                end
                                // writes refused without the latch set
                                sesc_pkg::OP_STATUS_WRITE: begin
                                    is_sr_next = 1'b1;
                                    state_next = wel_o ? sesc_pkg::SESC_WDATA
                                                       : sesc_pkg::SESC_IGNORE;
                                end
                                sesc_pkg::OP_READ: begin
                                    is_wr_next = 1'b0;
                                    state_next = sesc_pkg::SESC_ADDR;
                                end
                                sesc_pkg::OP_WRITE: begin
                                    is_wr_next = 1'b1;
                                    is_sr_next = 1'b0;
                                    state_next = wel_o ? sesc_pkg::SESC_ADDR
                                                       : sesc_pkg::SESC_IGNORE;
                                end
                                default: begin
                                    state_next = sesc_pkg::SESC_IGNORE;
                                end
                            endcase
                        end
                    end
                    sesc_pkg::SESC_ADDR: begin
                        addr_next = shin[sesc_pkg::ADDR_W-1:0];
                        mask_next = '0;
                        state_next = is_wr_reg ? sesc_pkg::SESC_WDATA : sesc_pkg::SESC_RDATA;
                    end
                    sesc_pkg::SESC_WDATA: begin
                        got_next = 1'b1;
                        if (is_sr_reg) begin
                            sr_data_next = shin[sesc_pkg::ST_BP_HI:sesc_pkg::ST_BP_LO];
                            // a second status byte is malformed: drop the command
                            if (got_reg) begin
                                state_next = sesc_pkg::SESC_IGNORE;
                            end
                        end else begin
                            // page roll-over keeps the upper address bits
                            buf_next[addr_reg[sesc_pkg::PAGE_W-1:0]] = shin;
                            mask_next[addr_reg[sesc_pkg::PAGE_W-1:0]] = 1'b1;
                            addr_next[sesc_pkg::PAGE_W-1:0] =
                                addr_reg[sesc_pkg::PAGE_W-1:0] + 4'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        standby_next = (state_next == sesc_pkg::SESC_STANDBY);
    end
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_reg <= sesc_pkg::SESC_RESET;
            sh_reg <= 8'h00;
            osh_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            out_cnt_reg <= 3'h0;
            addr_reg <= 7'h00;
            pend_op_reg <= 8'h00;
            {is_wr_reg, is_sr_reg, got_reg} <= 3'h0;
            buf_reg <= '0;
            mask_reg <= '0;
            sr_data_reg <= sesc_pkg::BP_RST;
            bp_o <= sesc_pkg::BP_RST;
            wcnt_reg <= 16'h0000;
            so_o <= 1'b0;
            so_oe_o <= 1'b0;
            busy_o <= 1'b0;
            wel_o <= sesc_pkg::WEL_RST;
            standby_o <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            sh_reg <= sh_next;
            osh_reg <= osh_next;
            bit_cnt_reg <= bit_cnt_next;
            out_cnt_reg <= out_cnt_next;
            addr_reg <= addr_next;
            pend_op_reg <= pend_op_next;
            {is_wr_reg, is_sr_reg, got_reg} <= {is_wr_next, is_sr_next, got_next};
            buf_reg <= buf_next;
            mask_reg <= mask_next;
            sr_data_reg <= sr_data_next;
            bp_o <= bp_next;
            wcnt_reg <= wcnt_next;
            so_o <= so_next;
            so_oe_o <= so_oe_next;
            busy_o <= busy_next;
            wel_o <= wel_next;
            standby_o <= standby_next;
        end
    end
    sesc_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .ce_i(ce_i),
        .req_i(mem_req),
        .rdata_o(mem_rdata)
    );
endmodule
`default_nettype wire

// ==== tb/sesc_ctrl_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module sesc_ctrl_chk (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic por_ok_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic busy_o,
    input wire logic wel_o,
    input wire logic standby_o,
    input wire logic [1:0] bp_o
);
    logic [15:0] run_reg;
    logic [15:0] run_next;
    always_comb begin
        run_next = (!resetn_i || !busy_o) ? 16'h0000 : run_reg + 16'h0001;
    end
    always_ff @(posedge ref_clk_i) begin
        run_reg <= run_next;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    por_drop_a:
    assert property ((!por_ok_i) [*5] |-> !wel_o && !busy_o && !standby_o)
        else $error("state kept after supply loss");
    por_entry_a:
    assert property ($rose(standby_o) && !$past(por_ok_i, 4) |-> !wel_o && !busy_o)
        else $error("standby entered with latch or busy set");
    busy_hold_a:
    assert property (disable iff (!resetn_i || !por_ok_i)
        busy_o && run_reg < sesc_pkg::WR_CYCLE_CNT - 16'h0001 |=> busy_o)
        else $error("write cycle ended early");
    busy_max_a:
    assert property (disable iff (!resetn_i || !por_ok_i)
        busy_o |-> run_reg < sesc_pkg::WR_CYCLE_CNT)
        else $error("write cycle too long");
    wel_rise_a:
    assert property ($rose(wel_o) |-> $past(cs_n_i, 3))
        else $error("latch set while selected");
    busy_rise_a:
    assert property ($rose(busy_o) |-> $past(cs_n_i, 3) && wel_o)
        else $error("write cycle started without deselect or latch");
    busy_end_a:
    assert property ($fell(busy_o) && por_ok_i |-> $fell(wel_o))
        else $error("latch not cleared at write end");
    so_release_a:
    assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("serial output driven while deselected");
    select_ready_a:
    assert property ((!cs_n_i && por_ok_i) [*6] |-> !standby_o)
        else $error("standby kept while selected");
    so_shift_a:
    assert property ($changed(so_o) && so_oe_o |-> !$past(sck_i, 3))
        else $error("serial output moved outside falling clock");
endmodule
bind sesc_ctrl sesc_ctrl_chk i_sesc_ctrl_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .por_ok_i(por_ok_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .busy_o(busy_o), .wel_o(wel_o),
    .standby_o(standby_o), .bp_o(bp_o));
`default_nettype wire

// ==== tb/sesc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module sesc_host (
    input wire logic clk_i,
    input wire logic so_i,
    output var sesc_pkg::sesc_pins_s pins_o
);
    // sck rests low between frames
    initial pins_o = 3'b100;
    task automatic hwait(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic frame(input int nb, input logic [63:0] v, output logic [63:0] q);
        q = 64'h0;
        pins_o.cs_n = 1'b0;
        hwait(4);
        for (int i = nb - 1; i >= 0; i--) begin
            pins_o.si = v[i];
            hwait(4);
            q[i] = so_i;
            pins_o.sck = 1'b1;
            hwait(4);
            pins_o.sck = 1'b0;
        end
        hwait(4);
        pins_o.cs_n = 1'b1;
        // released data line must not keep its last level
        pins_o.si = ~pins_o.si;
        hwait(8);
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic por_ok_i = 1'b0;
    logic oe_seen = 1'b0;
    logic oe_clr = 1'b0;
    sesc_pkg::sesc_pins_s pins;
    logic so_o, so_oe_o, busy_o, wel_o, standby_o;
    logic [1:0] bp_o;
    logic [63:0] q;
    logic [31:0] seed = 32'h0000002E;
    logic [7:0] a, d;
    int error_cnt = 0;
    int num_checks = 0;
    int m_wel = 0;
    int m_bp = 0;
    int run = 0;
    int last_len = 0;
    sesc_host i_sesc_host (.clk_i(ref_clk_i), .so_i(so_oe_o ? so_o : ~so_o), .pins_o(pins));
    sesc_ctrl i_sesc_ctrl (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .por_ok_i(por_ok_i), .cs_n_i(pins.cs_n), .sck_i(pins.sck), .si_i(pins.si),
        .so_o(so_o), .so_oe_o(so_oe_o), .busy_o(busy_o), .wel_o(wel_o),
        .standby_o(standby_o), .bp_o(bp_o));
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        oe_seen <= (oe_seen | so_oe_o) & ~oe_clr;
        if (busy_o === 1'b1) begin
            run <= run + 1;
        end else if (run > 0) begin
            last_len <= run;
            run <= 0;
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input int nb, input logic [63:0] v);
        i_sesc_host.frame(nb, v, q);
    endtask
    task automatic flags(input logic b);
        chk("flags", {14'h0000, 1'(m_wel), b}, {14'h0000, wel_o, busy_o});
    endtask
    task automatic st_chk(input logic b);
        cmd(16, 64'h0500);
        chk("status", {8'h00, 4'hF, 2'(m_bp), 1'(m_wel), b}, {8'h00, q[7:0]});
    endtask
    task automatic done_wait();
        int i;
        for (i = 0; i < 1100 && busy_o !== 1'b0; i++) begin
            @(negedge ref_clk_i);
        end
        if (i == 1100) begin
            error_cnt++;
            stop_test();
        end
        @(negedge ref_clk_i);
        m_wel = 0;
        chk("busy_len", sesc_pkg::WR_CYCLE_CNT, 16'(last_len));
        flags(1'b0);
    endtask
    task automatic por_on();
        int i;
        por_ok_i = 1'b1;
        for (i = 0; i < 20 && standby_o !== 1'b1; i++) begin
            @(negedge ref_clk_i);
        end
        if (i == 20) begin
            error_cnt++;
            stop_test();
        end
        repeat (2) @(negedge ref_clk_i);
        chk("standby", 16'h0001, {15'h0000, standby_o});
        m_wel = 0;
        flags(1'b0);
    endtask
    initial begin
        repeat (16) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        por_on();
        st_chk(1'b0);
        cmd(7, 64'h3);
        cmd(9, 64'hD);
        flags(1'b0);
        a = 8'(rnd()) & 8'h7F;
        d = 8'(rnd());
        cmd(24, {40'h0, 8'h02, a, d});
        flags(1'b0);
        for (int k = 0; k < 4; k++) begin
            oe_clr = 1'b1;
            @(negedge ref_clk_i);
            oe_clr = 1'b0;
            cmd(16, {48'h0, 8'h80 | 8'(rnd()), 8'h00});
            chk("so_oe", 16'h0000, {15'h0000, oe_seen});
        end
        cmd(8, 64'h06);
        m_wel = 1;
        st_chk(1'b0);
        cmd(8, 64'h04);
        m_wel = 0;
        flags(1'b0);
        cmd(8, 64'h06);
        m_wel = 1;
        cmd(16, {48'h0, 8'h01, d});
        st_chk(1'b1);
        cmd(8, 64'h04);
        flags(1'b1);
        done_wait();
        m_bp = int'(d[3:2]);
        chk("bp", {14'h0000, 2'(m_bp)}, {14'h0000, bp_o});
        cmd(8, 64'h06);
        m_wel = 1;
        cmd(24, {40'h0, 8'h02, a, d});
        cmd(24, {40'h0, 8'h02, a, ~d});
        done_wait();
        cmd(32, {32'h0, 8'h03, a, 16'h0000});
        chk("rdata", {8'h00, d}, {8'h00, q[15:8]});
        cmd(8, 64'h06);
        cmd(24, {40'h0, 8'h02, a, ~d});
        por_ok_i = 1'b0;
        repeat (10) @(negedge ref_clk_i);
        m_wel = 0;
        flags(1'b0);
        chk("standby", 16'h0000, {15'h0000, standby_o});
        por_on();
        stop_test();
    end
endmodule
`default_nettype wire
